/* ubg_pkg.sv */
// package: register map, field layouts and constants of the baud generator pair
package ubg_pkg;
  // register indices (printed offsets), byte address is four times the index
  localparam logic [7:0] IDX_RCV_STAT_CTRL = 8'h13;
  localparam logic [7:0] IDX_XMT_STAT_CTRL = 8'h15;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h17;
  localparam logic [7:0] IDX_BAUD_STATUS = 8'h18;
  // bank select sits above the in-bank index
  localparam int BANK_LSB = 10;
  // word index starts above the byte lanes
  localparam int IDX_LSB = 2;
  localparam logic [1:0] BANK_PORT1 = 2'h0;
  localparam logic [1:0] BANK_PORT2 = 2'h1;
  localparam int ADDR_W = 12;
  // transmit status/control field positions used here
  localparam int XSC_CLOCK_SOURCE_BIT = 7;
  localparam int XSC_SYNC_BIT = 4;
  localparam logic [7:0] XSC_IMPL_MASK = 8'hF3;
  localparam logic [7:0] RSC_IMPL_MASK = 8'hF7;
  // reset values
  localparam logic [7:0] BAUD_DIVISOR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // post dividers
  localparam int ASYNC_DIV = 64;
  localparam int SYNC_DIV = 4;
  localparam int POST_W = 6;
  // answer to an unmapped read
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] divisor;
    logic divisor_wr;
    logic sync_sel;
    logic internal_clk;
  } ubg_cfg_t;

  typedef struct packed {
    logic bit_tick;
    logic gen_active;
  } ubg_stat_t;
endpackage : ubg_pkg

/* ubg_timer.sv */
// free-running reload timer: one tick per divisor+1 clocks
`timescale 1ns/10ps
module ubg_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic [WIDTH-1:0] divisor_i,
  input wire logic restart_i,
  // output
  output logic tick_o
);
  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      count_reg <= '0;
    end else if (count_reg == divisor_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (count_reg == divisor_i);
    end
  end
endmodule : ubg_timer

/* ubg_postdiv.sv */
// post divider: turns timer ticks into bit-rate ticks, by 64 or by 4
`timescale 1ns/10ps
module ubg_postdiv #(
  parameter int WIDTH = ubg_pkg::POST_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic tick_i,
  input wire logic sync_sel_i,
  input wire logic restart_i,
  // output
  output logic bit_tick_o
);
  localparam logic [WIDTH-1:0] LAST_ASYNC = WIDTH'(ubg_pkg::ASYNC_DIV - 1);
  localparam logic [WIDTH-1:0] LAST_SYNC = WIDTH'(ubg_pkg::SYNC_DIV - 1);
  logic [WIDTH-1:0] pre_reg;
  logic [WIDTH-1:0] last;

  assign last = sync_sel_i ? LAST_SYNC : LAST_ASYNC;

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      pre_reg <= '0;
    end else if (tick_i) begin
      pre_reg <= (pre_reg >= last) ? '0 : pre_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= tick_i && (pre_reg >= last);
    end
  end
endmodule : ubg_postdiv

/* ubg_top.sv */
// two baud rate generators with their control registers on classic Wishbone
`timescale 1ns/10ps
module ubg_top #(
  parameter int NPORT = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ubg_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // rate outputs to the shift logic, one bit per port
  output logic [NPORT-1:0] bit_tick_o,
  output logic [NPORT-1:0] sync_mode_o,
  output logic [NPORT-1:0] rate_active_o
);
  logic [7:0] divisor_reg [NPORT];
  logic [7:0] xsc_reg [NPORT];
  logic [7:0] rsc_reg [NPORT];
  logic [NPORT-1:0] div_wr;
  logic [NPORT-1:0] tmr_tick;
  logic [NPORT-1:0] post_tick;
  ubg_pkg::ubg_cfg_t cfg [NPORT];
  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic [1:0] bank;
  logic [31:0] rd_next;

  // word index from byte address
  assign idx = adr_i[ubg_pkg::BANK_LSB-1:ubg_pkg::IDX_LSB];
  assign bank = {1'b0, adr_i[ubg_pkg::BANK_LSB]};
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_en = req && we_i && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      localparam logic [1:0] MY_BANK = (g == 0) ? ubg_pkg::BANK_PORT1 : ubg_pkg::BANK_PORT2;

      assign div_wr[g] = wr_en && (bank == MY_BANK) && (idx == ubg_pkg::IDX_BAUD_DIVISOR);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          divisor_reg[g] <= ubg_pkg::BAUD_DIVISOR_RST;
        end else if (div_wr[g]) begin
          divisor_reg[g] <= dat_i[7:0];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          xsc_reg[g] <= ubg_pkg::CTRL_RST;
          rsc_reg[g] <= ubg_pkg::CTRL_RST;
        end else if (wr_en && bank == MY_BANK) begin
          if (idx == ubg_pkg::IDX_XMT_STAT_CTRL) begin
            xsc_reg[g] <= dat_i[7:0] & ubg_pkg::XSC_IMPL_MASK;
          end
          if (idx == ubg_pkg::IDX_RCV_STAT_CTRL) begin
            rsc_reg[g] <= dat_i[7:0] & ubg_pkg::RSC_IMPL_MASK;
          end
        end
      end

      assign cfg[g].divisor = divisor_reg[g];
      assign cfg[g].divisor_wr = div_wr[g];
      assign cfg[g].sync_sel = xsc_reg[g][ubg_pkg::XSC_SYNC_BIT];
      assign cfg[g].internal_clk = xsc_reg[g][ubg_pkg::XSC_CLOCK_SOURCE_BIT];

      ubg_timer #(
        .WIDTH(8)
      ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(cfg[g].divisor),
        .restart_i(cfg[g].divisor_wr),
        .tick_o(tmr_tick[g])
      );

      ubg_postdiv #(
        .WIDTH(ubg_pkg::POST_W)
      ) u_post (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tmr_tick[g]),
        .sync_sel_i(cfg[g].sync_sel),
        .restart_i(cfg[g].divisor_wr),
        .bit_tick_o(post_tick[g])
      );

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          bit_tick_o[g] <= 1'b0;
          sync_mode_o[g] <= 1'b0;
          rate_active_o[g] <= 1'b0;
        end else begin
          // sync slave takes its timing from the external clock
          rate_active_o[g] <= !cfg[g].sync_sel || cfg[g].internal_clk;
          bit_tick_o[g] <= post_tick[g] && (!cfg[g].sync_sel || cfg[g].internal_clk);
          sync_mode_o[g] <= cfg[g].sync_sel;
        end
      end
    end
  endgenerate

  // read mux
  always_comb begin
    rd_next = ubg_pkg::UNMAPPED_DATA;
    for (int p = 0; p < NPORT; p++) begin
      if (bank == ((p == 0) ? ubg_pkg::BANK_PORT1 : ubg_pkg::BANK_PORT2)) begin
        unique case (idx)
          ubg_pkg::IDX_BAUD_DIVISOR: rd_next = {24'h00_0000, divisor_reg[p]};
          ubg_pkg::IDX_XMT_STAT_CTRL: rd_next = {24'h00_0000, xsc_reg[p]};
          ubg_pkg::IDX_RCV_STAT_CTRL: rd_next = {24'h00_0000, rsc_reg[p]};
          ubg_pkg::IDX_BAUD_STATUS: rd_next = {30'h0000_0000, sync_mode_o[p], rate_active_o[p]};
          default: rd_next = ubg_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= ubg_pkg::UNMAPPED_DATA;
    end else if (req && !we_i) begin
      dat_o <= rd_next;
    end
  end
endmodule : ubg_top

/* ubg_shift_model.sv */
// far-side shift logic stand-in: counts bit-rate ticks of each port
`timescale 1ns/10ps
module ubg_shift_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ticks in, counts out
  input wire logic [1:0] bit_tick_i,
  output logic [31:0] ticks_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ticks_o <= '0;
    end else begin
      ticks_o <= ticks_o + {15'h0000, bit_tick_i[1], 15'h0000, bit_tick_i[0]};
    end
  end
endmodule : ubg_shift_model

/* ubg_top_asserts.sv */
// checker: bus answer, reset state and tick spacing
`timescale 1ns/10ps
module ubg_top_asserts #(
  parameter int NPORT = 2
) (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ubg_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // rate outputs
  input wire logic [NPORT-1:0] bit_tick_o,
  input wire logic [NPORT-1:0] sync_mode_o,
  input wire logic [NPORT-1:0] rate_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = cyc_i && stb_i && !ack_o;
  wire logic dw = tk && we_i && sel_i[0] && adr_i[9:0] == 10'h05C;
  chk_ack_answer: assert property (tk |=> ack_o) else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
  chk_reset_state:
    assert property (disable iff (1'b0) rst_i |=> !ack_o && dat_o == '0 && bit_tick_o == '0
      && rate_active_o == '0) else $error("reset state");
  chk_async_gap:
    assert property (bit_tick_o[0] && !sync_mode_o[0] |=> (!bit_tick_o[0] || sync_mode_o[0]) [*8])
    else $error("gap");
  chk_tick_gap:
    assert property (bit_tick_o[1] |=> !bit_tick_o[1] [*3]) else $error("short gap");
  chk_slave_quiet:
    assert property ((bit_tick_o & ~rate_active_o & ~$past(rate_active_o)) == '0)
    else $error("slave tick");
  chk_restart_one:
    assert property (dw && !adr_i[10] |=> ##1 !bit_tick_o[0] [*3]) else $error("restart");
  chk_restart_two:
    assert property (dw && adr_i[10] |=> ##1 !bit_tick_o[1] [*3]) else $error("restart two");
  cover property (bit_tick_o[0] && sync_mode_o[0]);
  cover property (bit_tick_o[1] && !sync_mode_o[1]);
  cover property (dw && adr_i[10]);
endmodule : ubg_top_asserts

bind ubg_top ubg_top_asserts #(.NPORT(NPORT)) i_ubg_top_asserts (.*);

/* ubg_top_test.sv */
// bench: register access and rate checks of both ports
`timescale 1ns/10ps
module ubg_top_test;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [3:0] sel_i;
  logic [11:0] adr_i;
  logic [31:0] dat_i, dat_o, ticks;
  logic [1:0] bit_tick_o, sync_mode_o, rate_active_o;
  logic [7:0] q;
  logic [15:0] t0;
  logic [7:0] tx[4] = '{8'h02, 8'h00, 8'hFF, 8'h00};
  int miscompares = 0;
  int total_checks = 0;
  int n;
  ubg_top i_ubg_top (.*);
  ubg_shift_model i_ubg_shift_model (.clk_i, .rst_i, .bit_tick_i(bit_tick_o), .ticks_o(ticks));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
    total_checks++;
    if (v !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", s, e, v);
    end
  endtask : chk
  function automatic logic [11:0] ra(input int p, input int i);
    return 12'(p * 1024 + i * 4);
  endfunction : ra
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'h1, a, 24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    chk("bus ack", 16'(ack_o), 16'h0001);
    q = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : bus
  task automatic wt(input int p);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (bit_tick_o[p] !== 1'b1 && n < 5000);
  endtask : wt
  task automatic per(input int p, input int e);
    wt(p);
    wt(p);
    chk("period", 16'(n), 16'(e));
  endtask : per
  task automatic rst_pulse;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : rst_pulse
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = '0;
    rst_pulse();
    for (int p = 0; p < 2; p++) begin
      bus(1'b0, ra(p, 'h17), 8'h00);
      chk("divisor reset", 16'(q), 16'h0000);
    end
    bus(1'b0, ra(0, 'h3F), 8'h00);
    chk("unmapped", 16'(q), 16'h0000);
    bus(1'b1, ra(0, 'h17), 8'hA5);
    bus(1'b1, ra(1, 'h17), 8'h3C);
    bus(1'b0, ra(0, 'h17), 8'h00);
    chk("divisor one", 16'(q), 16'h00A5);
    bus(1'b0, ra(1, 'h17), 8'h00);
    chk("divisor two", 16'(q), 16'h003C);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ra(i / 2, 'h15), (i == 1 || i == 2) ? 8'h90 : 8'h80);
      bus(1'b1, ra(i / 2, 'h17), tx[i]);
      per(i / 2, ((i == 1 || i == 2) ? 4 : 64) * (tx[i] + 1));
    end
    $display("test rates done");
    bus(1'b1, ra(0, 'h17), 8'hFF);
    repeat (300) @(posedge clk_i);
    bus(1'b1, ra(0, 'h17), 8'h00);
    wt(0);
    chk("restart", 16'(n < 70), 16'h0001);
    bus(1'b1, ra(1, 'h15), 8'h10);
    repeat (4) @(posedge clk_i);
    chk("slave outputs", 16'({sync_mode_o[1], rate_active_o[1]}), 16'h0002);
    t0 = ticks[31:16];
    repeat (300) @(posedge clk_i);
    chk("slave ticks", ticks[31:16], t0);
    bus(1'b0, ra(1, 'h18), 8'h00);
    chk("slave status", 16'(q), 16'h0002);
    $display("test restart and slave done");
    rst_pulse();
    bus(1'b0, ra(1, 'h17), 8'h00);
    chk("divisor again", 16'(q), 16'h0000);
    bus(1'b1, ra(1, 'h17), 8'h01);
    per(1, 128);
    $display("test second reset done");
    summarize();
  end
endmodule : ubg_top_test
